// [core/accel_fifo_regs.vh]
// Operation
// - Z new-data flag sets on Z acquisition, clears on Z high-byte read.
// - Y new-data flag resets to 0, sets on Y acquisition, clears on read.
// - X new-data flag resets to 0, sets on X acquisition, clears on read.
// - With FIFO mode nonzero, offset 0x00 shows FIFO status instead.
// - FIFO status: overflow bit 7, watermark bit 6, count low; RO, zero.
// - Count gives stored samples: zero empty, one to 32 held.
// - Overflow flag holds while overflowed; a status read keeps it.
// - Watermark flag holds while count is at or above watermark.
// - In trigger mode 0b11 the watermark position shows trigger detected.
// - Status read clears FIFO interrupt source; flags stay while active.
// - Cleared FIFO source sets again on next sample if condition persists.
// - Trigger mode: enabled event flag freezes sample collection.
// - Trigger config 0x0A RW, zero reset, bits 5..1 enable events.
// - FIFO source bit sets on overflow, count reaching watermark, or trigger hit.
`ifndef ACCEL_FIFO_REGS_VH
`define ACCEL_FIFO_REGS_VH

// Register indices; the byte address is four times the index.
`define IDX_FIFO_STATUS   6'h00
`define IDX_TRIG_CONFIG   6'h0A
`define IDX_FIFO_CONTROL  6'h10
`define IDX_X_HIGH        6'h11
`define IDX_Y_HIGH        6'h12
`define IDX_Z_HIGH        6'h13
`define IDX_IRQ_STATUS    6'h14
`define IDX_IRQ_MASK      6'h15

`define RST_BYTE          8'h00
`define TRIG_EVENT_MASK   8'h3E

`define MODE_OFF          2'h0
`define MODE_CIRCULAR     2'h1
`define MODE_STOP         2'h2
`define MODE_TRIGGER      2'h3

`define FIFO_DEPTH        6'h20

`define IRQ_FIFO_BIT      0
`define IRQ_DATA_BIT      1
`define IRQ_TRIG_BIT      2

`endif

// [core/fifo_occupancy.v]
`timescale 1ns/1ns
`default_nettype none
`include "accel_fifo_regs.vh"
module fifo_occupancy (
   input  wire       core_clk_i,
   input  wire       sys_rst_i,
   input  wire [1:0] mode_i,
   input  wire       gate_i,
   input  wire       push_i,
   input  wire       pop_i,
   output wire [5:0] count_o,
   output wire       ovf_o
);

   reg  [5:0] count_r;
   reg  [5:0] count_nxt;
   reg        ovf_r;
   reg        ovf_nxt;
   wire       full;
   wire       empty;
   wire       push_ok;
   wire       pop_ok;

   assign full    = (count_r == `FIFO_DEPTH);
   assign empty   = (count_r == 6'h00);
   assign push_ok = push_i & ~gate_i & (mode_i != `MODE_OFF);
   assign pop_ok  = pop_i & ~empty;

   // -------------------------------------------------------------
   // Occupancy
   // -------------------------------------------------------------
   // A full circular FIFO drops its oldest sample, so the count stays
   // at the depth; in stop mode the new sample is lost instead.
   always @* begin
      count_nxt = count_r;
      ovf_nxt   = ovf_r;
      if (mode_i == `MODE_OFF) begin
         count_nxt = 6'h00;
         ovf_nxt   = 1'b0;
      end else begin
         if (push_ok & ~pop_ok & ~full) begin
            count_nxt = count_r + 6'h01;
         end else if (pop_ok & ~push_ok) begin
            count_nxt = count_r - 6'h01;
         end
         if (push_ok & full & ~pop_ok) begin
            ovf_nxt = 1'b1;
         end else if (pop_ok) begin
            ovf_nxt = 1'b0;
         end
      end
   end

   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         count_r <= 6'h00;
         ovf_r   <= 1'b0;
      end else begin
         count_r <= count_nxt;
         ovf_r   <= ovf_nxt;
      end
   end

   assign count_o = count_r;
   assign ovf_o   = ovf_r;

endmodule
`default_nettype wire

// [core/accel_fifo_status_trigger.v]
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "accel_fifo_regs.vh"
module accel_fifo_status_trigger (
   input  wire        core_clk_i,
   input  wire        sys_rst_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output wire        pready_o,
   output wire [31:0] prdata_o,
   output wire        pslverr_o,
   input  wire        x_acq_done_i,
   input  wire        y_acq_done_i,
   input  wire        z_acq_done_i,
   input  wire [7:0]  x_high_i,
   input  wire [7:0]  y_high_i,
   input  wire [7:0]  z_high_i,
   input  wire        sample_push_i,
   input  wire        sample_pop_i,
   input  wire [7:0]  event_flags_i,
   output wire        fifo_gate_o,
   output wire [5:0]  fifo_count_o,
   output wire        irq_o
);

   // -------------------------------------------------------------
   // Decoding helpers
   // -------------------------------------------------------------
   function is_mapped;
      input [5:0] idx;
      begin
         case (idx)
            `IDX_FIFO_STATUS  : is_mapped = 1'b1;
            `IDX_TRIG_CONFIG  : is_mapped = 1'b1;
            `IDX_FIFO_CONTROL : is_mapped = 1'b1;
            `IDX_X_HIGH       : is_mapped = 1'b1;
            `IDX_Y_HIGH       : is_mapped = 1'b1;
            `IDX_Z_HIGH       : is_mapped = 1'b1;
            `IDX_IRQ_STATUS   : is_mapped = 1'b1;
            `IDX_IRQ_MASK     : is_mapped = 1'b1;
            default           : is_mapped = 1'b0;
         endcase
      end
   endfunction

   function [7:0] set_clear;
      input [7:0] cur;
      input [7:0] clr;
      input [7:0] set;
      begin
         set_clear = (cur & ~clr) | set;
      end
   endfunction

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   wire [5:0]  idx;
   wire        setup_ph;
   wire        access_ph;
   wire        wr_acc;
   wire        rd_acc;
   wire        mapped;

   reg  [31:0] prdata_r;
   reg  [31:0] prdata_nxt;

   reg  [7:0]  trig_cfg_r;
   reg  [7:0]  fifo_ctl_r;
   reg  [7:0]  irq_stat_r;
   reg  [7:0]  irq_stat_nxt;
   reg  [7:0]  irq_mask_r;

   reg         xdr_r;
   reg         ydr_r;
   reg         zdr_r;
   reg         xdr_nxt;
   reg         ydr_nxt;
   reg         zdr_nxt;

   reg         trig_hit_r;
   reg         trig_hit_nxt;
   reg         push_seen_r;
   reg         wm_seen_r;

   wire [1:0]  fifo_mode;
   wire [5:0]  watermark;
   wire [5:0]  count;
   wire        ovf;
   wire        wm_cond;
   wire        fifo_on;
   wire        trig_mode;
   wire        trig_event;
   wire        fifo_evt;
   wire [7:0]  fifo_status;
   wire [7:0]  axis_data_ready_status;
   wire [7:0]  irq_set;
   wire [7:0]  irq_clr;

   // -------------------------------------------------------------
   // APB slave
   // -------------------------------------------------------------
   // The slave never stalls, so every access phase completes at once.
   assign idx       = paddr_i[7:2];
   assign mapped    = is_mapped(idx);
   assign setup_ph  = psel_i & ~penable_i;
   assign access_ph = psel_i & penable_i;
   assign wr_acc    = access_ph & pwrite_i;
   assign rd_acc    = access_ph & ~pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = access_ph & ~mapped;
   assign prdata_o  = prdata_r;

   // -------------------------------------------------------------
   // FIFO configuration and state
   // -------------------------------------------------------------
   assign fifo_mode = fifo_ctl_r[7:6];
   assign watermark = fifo_ctl_r[5:0];
   assign fifo_on   = (fifo_mode != `MODE_OFF);
   assign trig_mode = (fifo_mode == `MODE_TRIGGER);

   fifo_occupancy u_occupancy (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .mode_i     (fifo_mode),
      .gate_i     (trig_hit_r),
      .push_i     (sample_push_i),
      .pop_i      (sample_pop_i),
      .count_o    (count),
      .ovf_o      (ovf)
   );

   assign wm_cond = fifo_on & (count >= watermark);

   assign trig_event = |(event_flags_i & trig_cfg_r & `TRIG_EVENT_MASK);

   always @* begin
      trig_hit_nxt = trig_hit_r;
      if (!trig_mode) begin
         trig_hit_nxt = 1'b0;
      end else if (trig_event) begin
         trig_hit_nxt = 1'b1;
      end
   end

   assign fifo_gate_o  = trig_hit_r;
   assign fifo_count_o = count;

   assign fifo_status = {ovf, (trig_mode ? trig_hit_r : wm_cond), count};

   assign axis_data_ready_status = {4'h0, xdr_r | ydr_r | zdr_r, zdr_r, ydr_r, xdr_r};

   // -------------------------------------------------------------
   // New-data flags
   // -------------------------------------------------------------
   // A completion in the cycle of the clearing read keeps the flag set.
   always @* begin
      xdr_nxt = xdr_r;
      ydr_nxt = ydr_r;
      zdr_nxt = zdr_r;
      if (x_acq_done_i) begin
         xdr_nxt = 1'b1;
      end else if (rd_acc && idx == `IDX_X_HIGH) begin
         xdr_nxt = 1'b0;
      end
      if (y_acq_done_i) begin
         ydr_nxt = 1'b1;
      end else if (rd_acc && idx == `IDX_Y_HIGH) begin
         ydr_nxt = 1'b0;
      end
      if (z_acq_done_i) begin
         zdr_nxt = 1'b1;
      end else if (rd_acc && idx == `IDX_Z_HIGH) begin
         zdr_nxt = 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Interrupt source
   // -------------------------------------------------------------
   // The source is raised one cycle after the push that caused it,
   // once the count and overflow have settled.
   // overflow, watermark or trigger hit
   assign fifo_evt = (push_seen_r & (ovf | wm_cond))
                   | (wm_cond & ~wm_seen_r)
                   | (trig_hit_nxt & ~trig_hit_r);

   assign irq_set = {5'h00,
                     trig_hit_nxt & ~trig_hit_r,
                     x_acq_done_i | y_acq_done_i | z_acq_done_i,
                     fifo_evt};

   assign irq_clr = (wr_acc && idx == `IDX_IRQ_STATUS ? pwdata_i[7:0]
                                                       : 8'h00)
                  | {7'h00, rd_acc & fifo_on & (idx == `IDX_FIFO_STATUS)};

   always @* begin
      irq_stat_nxt = set_clear(irq_stat_r, irq_clr, irq_set);
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   // -------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------
   // Read data is captured in the setup cycle so that the bus sees a
   // flop output; a flag that sets between setup and access shows on
   // the next read.
   always @* begin
      prdata_nxt = 32'h0000_0000;
      case (idx)
         `IDX_FIFO_STATUS : begin
            prdata_nxt[7:0] = fifo_on ? fifo_status : axis_data_ready_status;
         end
         `IDX_TRIG_CONFIG : begin
            prdata_nxt[7:0] = trig_cfg_r;
         end
         `IDX_FIFO_CONTROL : begin
            prdata_nxt[7:0] = fifo_ctl_r;
         end
         `IDX_X_HIGH : begin
            prdata_nxt[7:0] = x_high_i;
         end
         `IDX_Y_HIGH : begin
            prdata_nxt[7:0] = y_high_i;
         end
         `IDX_Z_HIGH : begin
            prdata_nxt[7:0] = z_high_i;
         end
         `IDX_IRQ_STATUS : begin
            prdata_nxt[7:0] = irq_stat_r;
         end
         `IDX_IRQ_MASK : begin
            prdata_nxt[7:0] = irq_mask_r;
         end
         default : begin
            prdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         prdata_r    <= 32'h0000_0000;
         trig_cfg_r  <= `RST_BYTE;
         fifo_ctl_r  <= `RST_BYTE;
         irq_stat_r  <= `RST_BYTE;
         irq_mask_r  <= `RST_BYTE;
         xdr_r       <= 1'b0;
         ydr_r       <= 1'b0;
         zdr_r       <= 1'b0;
         trig_hit_r  <= 1'b0;
         push_seen_r <= 1'b0;
         wm_seen_r   <= 1'b0;
      end else begin
         if (setup_ph && !pwrite_i) begin
            prdata_r <= prdata_nxt;
         end
         if (wr_acc) begin
            case (idx)
               `IDX_TRIG_CONFIG : begin
                  trig_cfg_r <= pwdata_i[7:0];
               end
               `IDX_FIFO_CONTROL : begin
                  fifo_ctl_r <= pwdata_i[7:0];
               end
               `IDX_IRQ_MASK : begin
                  irq_mask_r <= pwdata_i[7:0];
               end
               default : begin
                  irq_mask_r <= irq_mask_r;
               end
            endcase
         end
         irq_stat_r  <= irq_stat_nxt;
         xdr_r       <= xdr_nxt;
         ydr_r       <= ydr_nxt;
         zdr_r       <= zdr_nxt;
         trig_hit_r  <= trig_hit_nxt;
         push_seen_r <= sample_push_i & ~trig_hit_r & fifo_on;
         wm_seen_r   <= wm_cond;
      end
   end

endmodule
`default_nettype wire

// [test/fifo_chk_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module fifo_chk (
   input wire logic        core_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        sample_push_i,
   input wire logic        sample_pop_i,
   input wire logic        fifo_gate_o,
   input wire logic [5:0]  fifo_count_o,
   input wire logic        irq_o
);
   // ------------------------------
   // Bus phases
   // ------------------------------
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [5:0] idx;
   logic       mapped;
   assign idx = paddr_i[7:2];
   assign mapped = idx == 6'h00 || idx == 6'h0A
                   || (idx >= 6'h10 && idx <= 6'h15);
   sequence setup_s;
      psel_i && !penable_i;
   endsequence
   sequence access_s;
      psel_i && penable_i;
   endsequence
   // ------------------------------
   // Checks
   // ------------------------------
   chk_access_ready: assert property (setup_s ##1 access_s |-> pready_o)
      else $error("no ready in access");
   chk_map_error: assert property (access_s |-> pslverr_o == !mapped)
      else $error("error flag wrong");
   chk_unmapped_zero: assert property (
      setup_s ##1 (psel_i && penable_i && !pwrite_i && !mapped)
      |-> prdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_upper_zero: assert property (prdata_o[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   chk_count_bound: assert property (fifo_count_o <= 6'h20)
      else $error("count above depth");
   // A frozen buffer may be drained or cleared but never grows.
   chk_gate_freeze: assert property (
      fifo_gate_o |=> fifo_count_o <= $past(fifo_count_o))
      else $error("count grew while gated");
   chk_empty_pop: assert property (
      fifo_count_o == 6'h00 && sample_pop_i && !sample_push_i
      |=> fifo_count_o == 6'h00)
      else $error("pop from empty moved count");
   chk_reset_clear: assert property (
      $fell(sys_rst_i) |-> !irq_o && !fifo_gate_o
      && fifo_count_o == 6'h00)
      else $error("state not cleared by reset");
endmodule
bind accel_fifo_status_trigger fifo_chk fifo_chk_i (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .sample_push_i(sample_push_i), .sample_pop_i(sample_pop_i),
   .fifo_gate_o(fifo_gate_o), .fifo_count_o(fifo_count_o), .irq_o(irq_o));
`default_nettype wire

// [test/sensor_source.sv]
`timescale 1ns/1ns
`default_nettype none
module sensor_source (
   input wire logic  core_clk_i,
   output logic       x_acq_o,
   output logic       y_acq_o,
   output logic       z_acq_o,
   output logic [7:0] x_high_o,
   output logic [7:0] y_high_o,
   output logic [7:0] z_high_o,
   output logic       push_o,
   output logic       pop_o,
   output logic [7:0] ev_o
);
   // ------------------------------
   // Sample timing
   // ------------------------------
   // Each acquisition loads a distinct byte per axis so that a swapped
   // read path shows up.
   initial begin
      {x_acq_o, y_acq_o, z_acq_o, push_o, pop_o} = 5'h00;
      {x_high_o, y_high_o, z_high_o} = 24'h00_0000;
      ev_o = 8'h00;
   end
   task acq(input int a);
      @(posedge core_clk_i);
      x_acq_o <= a == 0;
      y_acq_o <= a == 1;
      z_acq_o <= a == 2;
      if (a == 0) begin
         x_high_o <= 8'h11;
      end
      if (a == 1) begin
         y_high_o <= 8'h22;
      end
      if (a == 2) begin
         z_high_o <= 8'h33;
      end
      @(posedge core_clk_i);
      {x_acq_o, y_acq_o, z_acq_o} <= 3'h0;
   endtask
   task push(input int n);
      repeat (n) begin
         @(posedge core_clk_i);
         push_o <= 1'b1;
         @(posedge core_clk_i);
         push_o <= 1'b0;
      end
   endtask
   task pop1;
      @(posedge core_clk_i);
      pop_o <= 1'b1;
      @(posedge core_clk_i);
      pop_o <= 1'b0;
   endtask
   task ev(input logic [7:0] v);
      @(posedge core_clk_i);
      ev_o <= v;
   endtask
endmodule
`default_nettype wire

// [test/test_accel_fifo_status_trigger.sv]
`timescale 1ns/1ns
`default_nettype none
module test_accel_fifo_status_trigger;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err;
   logic [7:0]  addr = 0, xh, yh, zh, ev;
   logic [31:0] wdat = 0, rdat;
   wire logic   rdy, slv, gate, irq, xa, ya, za, push, pop;
   wire logic [31:0] prd;
   wire logic [5:0]  cnt;
   integer      n_mismatch = 0, num_checks = 0, i;
   always #20 clk = ~clk;
   sensor_source sensor_source_i (.core_clk_i(clk), .x_acq_o(xa),
      .y_acq_o(ya), .z_acq_o(za), .x_high_o(xh), .y_high_o(yh),
      .z_high_o(zh), .push_o(push), .pop_o(pop), .ev_o(ev));
   accel_fifo_status_trigger accel_fifo_status_trigger_i (
      .core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .pready_o(rdy),
      .prdata_o(prd), .pslverr_o(slv), .x_acq_done_i(xa),
      .y_acq_done_i(ya), .z_acq_done_i(za), .x_high_i(xh), .y_high_i(yh),
      .z_high_i(zh), .sample_push_i(push), .sample_pop_i(pop),
      .event_flags_i(ev), .fifo_gate_o(gate), .fifo_count_o(cnt),
      .irq_o(irq));
   // ------------------------------
   // Access tasks
   // ------------------------------
   task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rdat = prd;
      err = slv;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk($sformatf("read %h", a), rdat, e);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task lvl(input string nm, input logic e);
      @(negedge clk);
      chk(nm, (nm == "irq") ? irq : gate, e);
   endtask
   task close_out;
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(8'h00, 8'h00);
      rd(8'h28, 8'h00);
      wr(8'h28, 8'hFF);
      rd(8'h28, 8'hFF);
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'h00);
      bus(1'b0, 8'h0C, 32'h0000_0000);
      chk("unmapped error", err, 1'b1);
      for (i = 0; i < 3; i++) begin
         sensor_source_i.acq(i);
         rd(8'h00, 8'h08 | (8'h01 << i));
         rd(8'(8'h44 + 4 * i), 8'(8'h11 * (i + 1)));
         rd(8'h00, 8'h00);
      end
      wr(8'h40, 8'h44);
      sensor_source_i.push(3);
      rd(8'h00, 8'h03);
      sensor_source_i.push(1);
      rd(8'h00, 8'h44);
      rd(8'h50, 8'h02);
      sensor_source_i.push(1);
      rd(8'h50, 8'h03);
      wr(8'h54, 8'h01);
      lvl("irq", 1'b1);
      wr(8'h50, 8'h03);
      lvl("irq", 1'b0);
      sensor_source_i.push(27);
      rd(8'h00, 8'h60);
      sensor_source_i.push(1);
      rd(8'h00, 8'hE0);
      rd(8'h00, 8'hE0);
      lvl("irq", 1'b0);
      sensor_source_i.pop1;
      rd(8'h00, 8'h5F);
      chk("count", cnt, 32'h0000_001F);
      for (i = 0; i < 8; i++) begin
         wr(8'h40, 8'h00);
         wr(8'h40, 8'hE0);
         wr(8'h28, 8'h01 << i);
         sensor_source_i.ev(8'h01 << i);
         sensor_source_i.push(1);
         lvl("gate", i >= 1 && i <= 5);
         rd(8'h00, (i >= 1 && i <= 5) ? 8'h40 : 8'h01);
         sensor_source_i.ev(8'h00);
         sensor_source_i.pop1;
      end
      close_out;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out;
   end
endmodule
`default_nettype wire
